// >>> bench/sfr_host_model.sv
// Purpose: Host controller side of the serial link
// Assumes: Tasks are entered at a rising CLK edge
// Notes: Serial clock is eight CLK periods, low outside frames
module sfr_host_model (
	// Clock
	input wire logic clk,
	// Link outputs
	output logic sclk,
	output logic cs_n,
	output logic [3:0] hd,
	output logic [3:0] hoe_n,
	// Resolved pins
	input wire logic [3:0] pins
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		hd = 4'h0;
		hoe_n = 4'hf;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic start();
		wt(1);
		cs_n <= 1'b0;
		wt(4);
	endtask
	task automatic stop();
		hoe_n <= 4'hf;
		sclk <= 1'b0;
		wt(2);
		cs_n <= 1'b1;
		wt(8);
	endtask
	// Sampled late in the high phase, well after the device settles
	task automatic xfer(input logic [31:0] v, input int n, input int w, input bit drv,
		output logic [31:0] r);
		logic [3:0] m;
		m = (w == 4) ? 4'hf : (w == 2) ? 4'h3 : 4'h1;
		r = 32'h0;
		for (int i = 0; i < n; i++) begin
			sclk <= 1'b0;
			hd <= m & 4'(v >> (w * (n - 1 - i)));
			hoe_n <= drv ? ~m : 4'hf;
			wt(4);
			sclk <= 1'b1;
			wt(4);
			r = (r << w) | ((w == 1) ? {31'h0, pins[1]} : {28'h0, pins & m});
		end
	endtask
endmodule

// >>> bench/sfr_read_path_monitor.sv
// Purpose: Port assertions for the read path
// Assumes: Bound to sfr_read_path, one clock domain
// Notes: Spans of six cycles let the link synchronisers settle
module sfr_read_path_monitor (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// Link
	input wire logic CS_N,
	input wire logic IO0_OE_N,
	input wire logic IO1_OE_N,
	input wire logic IO2_OE_N,
	input wire logic IO3_OE_N,
	// Status
	input wire logic WRITE_IN_PROGRESS_FLAG,
	input wire logic QUAD_IO_ENABLE_BIT,
	input wire logic READ_ACTIVE,
	input wire logic WRAP_DISABLE_BIT,
	input wire logic [1:0] WRAP_LENGTH_BITS,
	// Memory port
	input wire logic MEM_RD_REQ,
	input wire logic [23:0] MEM_RD_ADDR
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] busy_r;
	logic [2:0] noqe_r;
	logic have_r;
	logic [23:0] last_r;
	wire idle_w = IO0_OE_N & IO1_OE_N & IO2_OE_N & IO3_OE_N;
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	// Counted only while deselected, so a flag raised mid-frame is not judged
	always @(posedge CLK) begin
		if (RESET || !WRITE_IN_PROGRESS_FLAG) busy_r <= 3'h0;
		else if (CS_N && busy_r != 3'h7) busy_r <= busy_r + 3'h1;
		if (RESET || QUAD_IO_ENABLE_BIT) noqe_r <= 3'h0;
		else if (CS_N && noqe_r != 3'h7) noqe_r <= noqe_r + 3'h1;
		if (RESET || CS_N) have_r <= 1'b0;
		else if (MEM_RD_REQ) have_r <= 1'b1;
		if (MEM_RD_REQ) last_r <= MEM_RD_ADDR;
	end
	a_req_single: assert property (MEM_RD_REQ |=> !MEM_RD_REQ)
		else $error("read request longer than one cycle");
	a_addr_step: assert property (MEM_RD_REQ && have_r && WRAP_DISABLE_BIT |->
		MEM_RD_ADDR == last_r + 24'h1) else $error("address did not advance by one");
	a_cs_release: assert property (CS_N [*6] |-> idle_w)
		else $error("lines driven while deselected");
	a_busy_quiet: assert property (busy_r >= 3'h6 |-> !MEM_RD_REQ && idle_w)
		else $error("read served while busy");
	a_noqe_quiet: assert property (noqe_r >= 3'h6 |-> IO2_OE_N && IO3_OE_N)
		else $error("quad lines driven without quad enable");
	a_data_phase: assert property ($fell(IO1_OE_N) |-> READ_ACTIVE)
		else $error("output enabled outside data phase");
	a_dual_lanes: assert property (!IO0_OE_N |-> !IO1_OE_N)
		else $error("lane 0 driven without lane 1");
	a_quad_lanes: assert property (!IO2_OE_N |-> !IO3_OE_N && !IO0_OE_N)
		else $error("quad lanes not driven together");
	a_wrap_reset: assert property ($fell(RESET) |-> WRAP_DISABLE_BIT && !WRAP_LENGTH_BITS)
		else $error("wrap setting not at reset value");
	a_wrap_steady: assert property (CS_N [*6] |=> $stable({WRAP_DISABLE_BIT, WRAP_LENGTH_BITS}))
		else $error("wrap setting changed while idle");
endmodule

bind sfr_read_path sfr_read_path_monitor i_mon (
	.CLK(CLK), .RESET(RESET), .CS_N(CS_N),
	.IO0_OE_N(IO0_OE_N), .IO1_OE_N(IO1_OE_N), .IO2_OE_N(IO2_OE_N), .IO3_OE_N(IO3_OE_N),
	.WRITE_IN_PROGRESS_FLAG(WRITE_IN_PROGRESS_FLAG), .QUAD_IO_ENABLE_BIT(QUAD_IO_ENABLE_BIT),
	.READ_ACTIVE(READ_ACTIVE), .WRAP_DISABLE_BIT(WRAP_DISABLE_BIT),
	.WRAP_LENGTH_BITS(WRAP_LENGTH_BITS), .MEM_RD_REQ(MEM_RD_REQ), .MEM_RD_ADDR(MEM_RD_ADDR)
);

// >>> bench/sfr_read_path_test.sv
// Purpose: Self-checking bench for the read path
// Assumes: Pull-ups on all four data lines
// Notes: Memory model answers one cycle after each request
`include "sfr_map.vh"
module sfr_read_path_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic write_in_progress_flag = 1'b0;
	logic qe = 1'b1;
	logic mvalid = 1'b0;
	logic [7:0] mdata = 8'h00;
	logic sclk, cs_n, mreq, ract, cact, wdis;
	logic [3:0] hd, hoe_n, pins, dout, doe_n;
	logic [23:0] maddr;
	logic [1:0] wlen;
	logic [31:0] r;
	int err_total = 0;
	int num_checks = 0;
	int reqs = 0;
	int oe_cnt = 0;
	assign pins = (~doe_n & dout) | (doe_n & ~hoe_n & hd) | (doe_n & hoe_n);
	initial forever #20 clk = ~clk;
	sfr_read_path i_dut (
		.CLK(clk), .RESET(rst), .SCLK(sclk), .CS_N(cs_n),
		.IO0_IN(pins[0]), .IO0_OUT(dout[0]), .IO0_OE_N(doe_n[0]),
		.IO1_IN(pins[1]), .IO1_OUT(dout[1]), .IO1_OE_N(doe_n[1]),
		.IO2_IN(pins[2]), .IO2_OUT(dout[2]), .IO2_OE_N(doe_n[2]),
		.IO3_IN(pins[3]), .IO3_OUT(dout[3]), .IO3_OE_N(doe_n[3]),
		.WRITE_IN_PROGRESS_FLAG(write_in_progress_flag), .QUAD_IO_ENABLE_BIT(qe),
		.MEM_RD_REQ(mreq), .MEM_RD_ADDR(maddr), .MEM_RD_VALID(mvalid), .MEM_RD_DATA(mdata),
		.READ_ACTIVE(ract), .CONT_READ_ACTIVE(cact), .WRAP_DISABLE_BIT(wdis),
		.WRAP_LENGTH_BITS(wlen)
	);
	sfr_host_model i_host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .hd(hd), .hoe_n(hoe_n),
		.pins(pins));
	function automatic logic [7:0] mem_val(input logic [23:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5a;
	endfunction
	// ----------------------------------------
	// Memory model and activity counters
	// ----------------------------------------
	always @(posedge clk) begin
		mvalid <= (mreq === 1'b1);
		mdata <= (mreq === 1'b1) ? mem_val(maddr) : ~mdata;
		reqs <= reqs + int'(mreq === 1'b1);
		oe_cnt <= oe_cnt + int'(doe_n !== 4'hf);
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rd_bytes(input logic [23:0] a, input int n, input int w, input int wrap);
		for (int i = 0; i < n; i++) begin
			i_host.xfer(0, 8 / w, w, 0, r);
			check(r[7:0], mem_val(a));
			a = wrap ? {a[23:3], a[2:0] + 3'h1} : a + 24'h1;
		end
	endtask
	task automatic flags(input logic w, input logic q);
		@(posedge clk);
		write_in_progress_flag <= w;
		qe <= q;
	endtask
	task automatic set_wrap(input logic [7:0] w8);
		i_host.start();
		i_host.xfer(`SFR_OP_SET_WRAP, 8, 1, 1, r);
		i_host.xfer({24'h0, w8}, 32, 1, 1, r);
		i_host.stop();
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		check({ract, cact, wdis, wlen}, 5'b00100);
		$display("test reset done");
	endtask
	task automatic t_out();
		logic [7:0] ops [4] = '{`SFR_OP_READ, `SFR_OP_FAST, `SFR_OP_DUAL_OUT, `SFR_OP_QUAD_OUT};
		for (int k = 0; k < 4; k++) begin
			i_host.start();
			i_host.xfer(ops[k], 8, 1, 1, r);
			i_host.xfer(32'h0012fe, 24, 1, 1, r);
			if (k > 0) i_host.xfer(0, 8, 1, 0, r);
			rd_bytes(24'h0012fe, 3, (k < 2) ? 1 : 2 * (k - 1), 0);
			i_host.stop();
		end
		$display("test output reads done");
	endtask
	task automatic t_refuse();
		logic [7:0] ops [4] = '{`SFR_OP_READ, `SFR_OP_DUAL_OUT, `SFR_OP_QUAD_OUT, `SFR_OP_QUAD_IO};
		int r0, o0;
		for (int k = 0; k < 4; k++) begin
			flags(k < 2, k < 2);
			i_host.wt(8);
			r0 = reqs;
			o0 = oe_cnt;
			i_host.start();
			i_host.xfer(ops[k], 8, 1, 1, r);
			i_host.xfer(32'h000100, 24, 1, 1, r);
			i_host.xfer(0, 16, 1, 0, r);
			i_host.stop();
			check(32'(reqs - r0), 0);
			check(32'(oe_cnt - o0), 0);
		end
		flags(1'b0, 1'b1);
		$display("test refused reads done");
	endtask
	task automatic cont_frame(input bit first, input int w, input logic [23:0] a);
		i_host.start();
		if (first)
			i_host.xfer((w == 4) ? `SFR_OP_QUAD_IO : `SFR_OP_DUAL_IO, 8, 1, 1, r);
		i_host.xfer(a, 24 / w, w, 1, r);
		i_host.xfer(8'h2f, 8 / w, w, 1, r);
		if (w == 4) i_host.xfer(0, 4, 4, 0, r);
		rd_bytes(a, 3, w, w == 4);
		i_host.stop();
		check(cact, 1'b1);
	endtask
	task automatic t_cont();
		set_wrap(8'h8f);
		check({wdis, wlen}, 3'b000);
		for (int w = 2; w <= 4; w += 2) begin
			cont_frame(1, w, 24'h0a0b06);
			cont_frame(0, w, 24'h00003f);
			i_host.start();
			i_host.xfer(32'hffffffff, 32 / w, 1, 1, r);
			i_host.stop();
			check(cact, 1'b0);
		end
		$display("test continuous and wrapped reads done");
	endtask
	task automatic t_wrap_len();
		for (int l = 0; l < 4; l++) begin
			set_wrap({1'b0, 2'(l), 1'b0, 4'hf});
			check({wdis, wlen}, {1'b0, 2'(l)});
		end
		set_wrap(8'h10);
		check({wdis, wlen}, 3'b100);
		$display("test wrap settings done");
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_out();
		t_refuse();
		t_cont();
		t_wrap_len();
		complete_run();
	end
	initial begin
		#2000000;
		err_total++;
		$display("[ERR] %0t watchdog expired", $time);
		complete_run();
	end
endmodule

// >>> hdl/sfr_fifo.v
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: One clock, synchronous active-high reset
// Notes: Flush empties it in one cycle
module sfr_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	input wire clk,
	input wire rst,
	input wire flush,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem_r [0:DEPTH-1];
	reg [AW-1:0] wr_r;
	reg [AW-1:0] rd_r;
	reg [AW:0] cnt_r;
	wire push;
	wire pop;

	assign in_ready = (cnt_r != DEPTH[AW:0]);
	assign out_valid = (cnt_r != {(AW+1){1'b0}});
	assign out_data = mem_r[rd_r];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always @(posedge clk) begin
		if (push) begin
			mem_r[wr_r] <= in_data;
		end
	end

	always @(posedge clk) begin
		if (rst || flush) begin
			wr_r <= {AW{1'b0}};
			rd_r <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_r <= wr_r + {{(AW-1){1'b0}}, 1'b1};
			end
			if (pop) begin
				rd_r <= rd_r + {{(AW-1){1'b0}}, 1'b1};
			end
			if (push && !pop) begin
				cnt_r <= cnt_r + {{AW{1'b0}}, 1'b1};
			end else if (pop && !push) begin
				cnt_r <= cnt_r - {{AW{1'b0}}, 1'b1};
			end
		end
	end
endmodule

// >>> hdl/sfr_read_path.v
// Purpose: Read-instruction front end of a serial NOR flash
// Assumes: Link pins oversampled by CLK, memory answers one cycle after a request
// Notes: Only read and burst-wrap instructions are decoded, others are skipped
`include "sfr_map.vh"

// Behaviour
// [RULE1] Opcode and 24-bit address sampled on rising
// [RULE2] Data shifted out MSB first on falling
// [RULE3] Address advances per byte until chip select
// [RULE4] Reads ignored while write in progress
// [RULE5] Normal read accepted on single line only
// [RULE6] Fast read adds eight dummy clocks
// [RULE7] Dual output: eight dummies, two bits per clock
// [RULE8] Host releases input before first data fall
// [RULE9] Quad output: eight dummies, four bits per clock
// [RULE10] Quad output refused without quad enable
// [RULE11] Host releases all lines before data
// [RULE12] Dual I/O: address and data two-wide
// [RULE13] Mode byte follows address, upper nibble used
// [RULE14] Dual mode bits 10 skip next opcode
// [RULE15] Other mode bits require opcode again
// [RULE16] Host sends sixteen ones to exit dual
// [RULE17] Quad I/O: four-wide, four dummy clocks
// [RULE18] Quad I/O only with quad enable set
// [RULE19] Quad mode bits 10 skip next opcode
// [RULE20] Host sends eight ones to exit quad
// [RULE21] Wrapped quad I/O stays in aligned section
// [RULE22] Wrap setting: disable bit and length bits
// [RULE23] Wrap command: 24 dummies, 8 wrap bits
// [RULE24] Wrap persists, resets disabled, 8 to 64
// [RULE25] Busy and quad gating on all reads
module sfr_read_path (
	// Clock and reset
	input wire CLK,
	input wire RESET,
	// Serial link
	input wire SCLK,
	input wire CS_N,
	input wire IO0_IN,
	output wire IO0_OUT,
	output wire IO0_OE_N,
	input wire IO1_IN,
	output wire IO1_OUT,
	output wire IO1_OE_N,
	input wire IO2_IN,
	output wire IO2_OUT,
	output wire IO2_OE_N,
	input wire IO3_IN,
	output wire IO3_OUT,
	output wire IO3_OE_N,
	// Status inputs
	input wire WRITE_IN_PROGRESS_FLAG,
	input wire QUAD_IO_ENABLE_BIT,
	// Memory read port
	output wire MEM_RD_REQ,
	output wire [23:0] MEM_RD_ADDR,
	input wire MEM_RD_VALID,
	input wire [7:0] MEM_RD_DATA,
	// Status outputs
	output wire READ_ACTIVE,
	output wire CONT_READ_ACTIVE,
	output wire WRAP_DISABLE_BIT,
	output wire [1:0] WRAP_LENGTH_BITS
);
	localparam ST_IDLE = 3'd0;
	localparam ST_CMD = 3'd1;
	localparam ST_ADDR = 3'd2;
	localparam ST_MODE = 3'd3;
	localparam ST_DUMMY = 3'd4;
	localparam ST_DATA = 3'd5;
	localparam ST_WRAP = 3'd6;
	localparam ST_SKIP = 3'd7;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	reg [5:0] sync1_r;
	reg [5:0] sync2_r;
	reg sclk_d_r;
	wire sclk_rise;
	wire sclk_fall;
	wire cs_n_s;
	wire [3:0] io_s;

	always @(posedge CLK) begin
		if (RESET) begin
			// SCLK bit idles low like its delayed copy, so no false edge
			sync1_r <= 6'h02;
			sync2_r <= 6'h02;
			sclk_d_r <= 1'b0;
		end else begin
			sync1_r <= {IO3_IN, IO2_IN, IO1_IN, IO0_IN, CS_N, SCLK};
			sync2_r <= sync1_r;
			sclk_d_r <= sync2_r[0];
		end
	end

	assign cs_n_s = sync2_r[1];
	assign io_s = sync2_r[5:2];
	assign sclk_rise = sync2_r[0] & ~sclk_d_r & ~cs_n_s;
	assign sclk_fall = ~sync2_r[0] & sclk_d_r & ~cs_n_s;

	// ----------------------------------------
	// State and registers
	// ----------------------------------------
	reg [2:0] state_r;
	reg [5:0] cnt_r;
	reg [31:0] in_r;
	reg [7:0] op_r;
	reg [1:0] in_w_r;
	reg [1:0] out_w_r;
	reg cont_r;
	reg wrap_dis_r;
	reg [1:0] wrap_len_r;
	reg [23:0] fetch_addr_r;
	reg fetch_on_r;
	reg pending_r;
	reg req_r;
	reg [7:0] out_sh_r;
	reg [3:0] left_r;
	reg [3:0] io_o_r;
	reg [3:0] io_oe_n_r;
	reg [31:0] in_nxt;
	reg [7:0] word;
	wire [7:0] op_in;
	wire busy;
	wire quad_op;
	wire [5:0] wmask;
	wire [6:0] wspan;
	wire [23:0] addr_inc;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [7:0] fifo_out_data;
	wire pop;

	// Serial input assembly, width picked by the current phase
	always @* begin
		case (in_w_r)
			`SFR_W2: in_nxt = {in_r[29:0], io_s[1:0]}; // [RULE12]
			`SFR_W4: in_nxt = {in_r[27:0], io_s}; // [RULE17]
			default: in_nxt = {in_r[30:0], io_s[0]}; // [RULE1]
		endcase
	end

	assign op_in = in_nxt[7:0];
	assign busy = WRITE_IN_PROGRESS_FLAG;
	assign quad_op = (op_in == `SFR_OP_QUAD_OUT) || (op_in == `SFR_OP_QUAD_IO);

	// ----------------------------------------
	// Instruction sequencer
	// ----------------------------------------
	always @(posedge CLK) begin
		if (RESET) begin
			state_r <= ST_IDLE;
			cnt_r <= 6'h00;
			in_r <= 32'h00000000;
			op_r <= 8'h00;
			in_w_r <= `SFR_W1;
			out_w_r <= `SFR_W1;
			cont_r <= 1'b0;
			wrap_dis_r <= `SFR_WRAP_DIS_RST; // [RULE24]
			wrap_len_r <= `SFR_WRAP_LEN_RST;
			fetch_on_r <= 1'b0;
		end else if (cs_n_s) begin
			// Chip select high ends any read
			state_r <= ST_IDLE; // [RULE3]
			fetch_on_r <= 1'b0;
		end else if (state_r == ST_IDLE) begin
			in_r <= 32'h00000000;
			if (!cont_r) begin
				state_r <= ST_CMD;
				cnt_r <= `SFR_CMD_CLKS;
				in_w_r <= `SFR_W1; // [RULE5]
			end else if (busy || (op_r == `SFR_OP_QUAD_IO && !QUAD_IO_ENABLE_BIT)) begin
				state_r <= ST_SKIP; // [RULE25]
			end else begin
				// Continuous mode goes straight to the address
				state_r <= ST_ADDR; // [RULE14] [RULE19]
				if (op_r == `SFR_OP_QUAD_IO) begin
					cnt_r <= `SFR_ADDR_CLKS_X4;
					in_w_r <= `SFR_W4;
				end else begin
					cnt_r <= `SFR_ADDR_CLKS_X2;
					in_w_r <= `SFR_W2;
				end
			end
		end else if (sclk_rise) begin
			in_r <= in_nxt;
			cnt_r <= cnt_r - 6'h01;
			case (state_r)
				ST_CMD: begin
					if (cnt_r == 6'h00) begin
						op_r <= op_in;
						cnt_r <= `SFR_ADDR_CLKS_X1;
						in_w_r <= `SFR_W1;
						state_r <= ST_ADDR;
						if (op_in == `SFR_OP_SET_WRAP) begin
							state_r <= ST_WRAP; // [RULE23]
							cnt_r <= `SFR_WRAP_CLKS;
						end else if (busy) begin
							state_r <= ST_SKIP; // [RULE4] [RULE25]
						end else if (quad_op && !QUAD_IO_ENABLE_BIT) begin
							state_r <= ST_SKIP; // [RULE10] [RULE18]
						end else begin
							case (op_in)
								`SFR_OP_READ, `SFR_OP_FAST: out_w_r <= `SFR_W1;
								`SFR_OP_DUAL_OUT: out_w_r <= `SFR_W2; // [RULE7]
								`SFR_OP_QUAD_OUT: out_w_r <= `SFR_W4; // [RULE9]
								`SFR_OP_DUAL_IO: begin
									out_w_r <= `SFR_W2;
									in_w_r <= `SFR_W2; // [RULE12]
									cnt_r <= `SFR_ADDR_CLKS_X2;
								end
								`SFR_OP_QUAD_IO: begin
									out_w_r <= `SFR_W4;
									in_w_r <= `SFR_W4; // [RULE17]
									cnt_r <= `SFR_ADDR_CLKS_X4;
								end
								default: state_r <= ST_SKIP;
							endcase
						end
					end
				end
				ST_ADDR: begin
					if (cnt_r == 6'h00) begin
						case (op_r)
							`SFR_OP_READ: begin
								state_r <= ST_DATA; // [RULE2]
								fetch_on_r <= 1'b1;
							end
							`SFR_OP_DUAL_IO: begin
								state_r <= ST_MODE; // [RULE13]
								cnt_r <= `SFR_MODE_CLKS_X2;
							end
							`SFR_OP_QUAD_IO: begin
								state_r <= ST_MODE;
								cnt_r <= `SFR_MODE_CLKS_X4;
							end
							default: begin
								state_r <= ST_DUMMY; // [RULE6]
								cnt_r <= `SFR_DUMMY_CLKS_FAST;
							end
						endcase
					end
				end
				ST_MODE: begin
					if (cnt_r == 6'h00) begin
						// Lower nibble of the mode byte is unused
						cont_r <= (in_nxt[`SFR_CONT_SEL_HI:`SFR_CONT_SEL_LO] ==
							`SFR_CONT_SEL_ON); // [RULE13] [RULE14] [RULE15] [RULE19]
						if (op_r == `SFR_OP_QUAD_IO) begin
							state_r <= ST_DUMMY; // [RULE17]
							cnt_r <= `SFR_DUMMY_CLKS_QIO;
						end else begin
							state_r <= ST_DATA;
							fetch_on_r <= 1'b1;
						end
					end
				end
				ST_DUMMY: begin
					if (cnt_r == 6'h00) begin
						state_r <= ST_DATA;
						fetch_on_r <= 1'b1;
					end
				end
				ST_WRAP: begin
					if (cnt_r == 6'h00) begin
						wrap_dis_r <= in_nxt[`SFR_WRAP_DIS_BIT]; // [RULE22] [RULE23]
						wrap_len_r <= in_nxt[`SFR_WRAP_LEN_HI:`SFR_WRAP_LEN_LO];
						state_r <= ST_SKIP;
					end
				end
				default: cnt_r <= cnt_r;
			endcase
		end
	end

	// ----------------------------------------
	// Memory fetch with address advance
	// ----------------------------------------
	// Section of up to 64 bytes, so six mask bits suffice
	assign wspan = (7'h08 << wrap_len_r) - 7'h01;
	assign wmask = wspan[5:0];
	assign addr_inc = (op_r == `SFR_OP_QUAD_IO && !wrap_dis_r) ?
		{fetch_addr_r[23:6], (fetch_addr_r[5:0] & ~wmask) |
		((fetch_addr_r[5:0] + 6'h01) & wmask)} : // [RULE21] [RULE24]
		fetch_addr_r + 24'h000001; // [RULE3]

	always @(posedge CLK) begin
		if (RESET) begin
			req_r <= 1'b0;
			pending_r <= 1'b0;
		end else begin
			req_r <= 1'b0;
			if (MEM_RD_VALID) begin
				pending_r <= 1'b0;
			end
			// Only one read outstanding, so the FIFO never overflows
			if (fetch_on_r && !cs_n_s && fifo_in_ready && !pending_r && !req_r) begin
				req_r <= 1'b1;
				pending_r <= 1'b1;
			end
		end
	end

	always @(posedge CLK) begin
		if (RESET) begin
			fetch_addr_r <= 24'h000000;
		end else if (req_r) begin
			fetch_addr_r <= addr_inc;
		end else if (sclk_rise && state_r == ST_ADDR && cnt_r == 6'h00) begin
			fetch_addr_r <= in_nxt[23:0];
		end
	end

	sfr_fifo #(
		.WIDTH(8),
		.DEPTH(4),
		.AW(2)
	) u_fifo (
		.clk(CLK),
		.rst(RESET),
		.flush(cs_n_s),
		.in_valid(MEM_RD_VALID & ~cs_n_s),
		.in_ready(fifo_in_ready),
		.in_data(MEM_RD_DATA),
		.out_valid(fifo_out_valid),
		.out_ready(pop),
		.out_data(fifo_out_data)
	);

	// ----------------------------------------
	// Output shifter on falling edges
	// ----------------------------------------
	assign pop = sclk_fall && state_r == ST_DATA && left_r == 4'h0 && fifo_out_valid;

	always @* begin
		word = (left_r == 4'h0) ? fifo_out_data : out_sh_r;
	end

	always @(posedge CLK) begin
		if (RESET || cs_n_s) begin
			out_sh_r <= 8'h00;
			left_r <= 4'h0;
			io_o_r <= 4'h0;
			io_oe_n_r <= 4'hf;
		end else if (sclk_fall && state_r == ST_DATA) begin
			// Host must have released its lines by this edge
			case (out_w_r)
				`SFR_W2: begin
					io_o_r <= {2'b00, word[7:6]}; // [RULE7] [RULE12]
					io_oe_n_r <= 4'hc; // [RULE8]
					out_sh_r <= {word[5:0], 2'b00};
					left_r <= ((left_r == 4'h0) ? 4'h8 : left_r) - 4'h2;
				end
				`SFR_W4: begin
					io_o_r <= word[7:4]; // [RULE9] [RULE17]
					io_oe_n_r <= 4'h0; // [RULE11]
					out_sh_r <= {word[3:0], 4'h0};
					left_r <= ((left_r == 4'h0) ? 4'h8 : left_r) - 4'h4;
				end
				default: begin
					io_o_r <= {2'b00, word[7], 1'b0}; // [RULE2]
					io_oe_n_r <= 4'hd;
					out_sh_r <= {word[6:0], 1'b0};
					left_r <= ((left_r == 4'h0) ? 4'h8 : left_r) - 4'h1;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	reg active_r;

	always @(posedge CLK) begin
		if (RESET) begin
			active_r <= 1'b0;
		end else begin
			active_r <= (state_r == ST_DATA) && !cs_n_s;
		end
	end

	assign IO0_OUT = io_o_r[0];
	assign IO1_OUT = io_o_r[1];
	assign IO2_OUT = io_o_r[2];
	assign IO3_OUT = io_o_r[3];
	assign IO0_OE_N = io_oe_n_r[0];
	assign IO1_OE_N = io_oe_n_r[1];
	assign IO2_OE_N = io_oe_n_r[2];
	assign IO3_OE_N = io_oe_n_r[3];
	assign MEM_RD_REQ = req_r;
	assign MEM_RD_ADDR = fetch_addr_r;
	assign READ_ACTIVE = active_r;
	assign CONT_READ_ACTIVE = cont_r;
	assign WRAP_DISABLE_BIT = wrap_dis_r;
	assign WRAP_LENGTH_BITS = wrap_len_r;
endmodule

// >>> pkg/sfr_map.vh
// Purpose: Constants for the serial flash read path
// Assumes: Included by the read path and its bench
// Notes: Definitions only
`ifndef SFR_MAP_VH
`define SFR_MAP_VH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define SFR_OP_READ 8'h03
`define SFR_OP_FAST 8'h0b
`define SFR_OP_DUAL_OUT 8'h3b
`define SFR_OP_QUAD_OUT 8'h6b
`define SFR_OP_DUAL_IO 8'hbb
`define SFR_OP_QUAD_IO 8'heb
`define SFR_OP_SET_WRAP 8'h77

// ----------------------------------------
// Phase lengths in serial clocks, minus one
// ----------------------------------------
`define SFR_CMD_CLKS 6'h07
`define SFR_ADDR_CLKS_X1 6'h17
`define SFR_ADDR_CLKS_X2 6'h0b
`define SFR_ADDR_CLKS_X4 6'h05
`define SFR_MODE_CLKS_X2 6'h03
`define SFR_MODE_CLKS_X4 6'h01
`define SFR_DUMMY_CLKS_FAST 6'h07
`define SFR_DUMMY_CLKS_QIO 6'h03
`define SFR_WRAP_CLKS 6'h1f

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define SFR_CONT_SEL_HI 5
`define SFR_CONT_SEL_LO 4
`define SFR_CONT_SEL_ON 2'b10
`define SFR_WRAP_DIS_BIT 4
`define SFR_WRAP_LEN_HI 6
`define SFR_WRAP_LEN_LO 5
`define SFR_WRAP_DIS_RST 1'b1
`define SFR_WRAP_LEN_RST 2'b00

// ----------------------------------------
// Line widths
// ----------------------------------------
`define SFR_W1 2'd0
`define SFR_W2 2'd1
`define SFR_W4 2'd2

`endif
